/* step_dir_microstep_frontend.sv */
// Step/direction front end with sine lookup, current scaling and chopper.
//
// How it works
// - direction sampled on each active step edge.
// - direction low counts up, high counts down.
// - rising edges only, or both, by mode.
// - step and direction glitch filtered, 60 ns.
// - sine table turns counter into coil targets.
// - multiplexer picks table or serial currents.
// - direct-tag serial commands set both coil currents.
// - scale targets down by scale or load.
// - drive phase ends when comparator trips.
// - bridge gate drives never overlap.
// - disabled power stage forces switches off.
// - internal oscillator used until clock pin goes high.
// - clock pin high disables oscillator until reset.
// - stall output high on detected stall.
// - test input selects test mode.
// - test mode: data is scan in, clock shifts.
// - step size follows resolution, full to 256.
// - step path on after reset until disabled.
// - 20-bit command in, 20-bit status out.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`include "step_map.svh"

module step_dir_microstep_frontend (
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [7:0]        paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              step_pin_in,
  input  wire logic              dir_pin_in,
  input  wire logic              serial_select_n_in,
  input  wire logic              serial_clock_in,
  input  wire logic              serial_data_in,
  output logic                   serial_data_out,
  output logic                   serial_data_enable_n_out,
  input  wire logic              factory_test_select_in,
  input  wire logic              ext_clock_pin_in,
  output logic                   oscillator_enable_out,
  output logic                   ext_clock_select_out,
  input  wire logic              power_stage_enable_n_in,
  input  wire logic              comparator_a_in,
  input  wire logic              comparator_b_in,
  input  wire logic [4:0]        load_limit_in,
  input  wire logic              stall_detect_in,
  output step_pkg::magnitude_t   coil_a_target_out,
  output logic                   coil_a_negative_out,
  output step_pkg::magnitude_t   coil_b_target_out,
  output logic                   coil_b_negative_out,
  output logic                   gate_a_high1_out,
  output logic                   gate_a_low1_out,
  output logic                   gate_a_high2_out,
  output logic                   gate_a_low2_out,
  output logic                   gate_b_high1_out,
  output logic                   gate_b_low1_out,
  output logic                   gate_b_high2_out,
  output logic                   gate_b_low2_out,
  output logic                   stall_flag_out,
  output logic                   test_mode_out
);
  import step_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [7:0] pins_meta;
  logic [7:0] pins_sync;

  always_ff @(posedge clk_in)
  begin
    pins_meta <= {serial_select_n_in, serial_clock_in, serial_data_in,
                  factory_test_select_in, ext_clock_pin_in,
                  power_stage_enable_n_in, comparator_a_in,
                  comparator_b_in};
    pins_sync <= pins_meta;
  end

  wire select_n_s, sck_s, sdi_s, test_s, extclk_s, enable_n_s;
  wire reached_a, reached_b;
  assign {select_n_s, sck_s, sdi_s, test_s, extclk_s, enable_n_s,
          reached_a, reached_b} = pins_sync;

  //////////////////////////////////////////////////////////////////////////
  // Step and direction filters.
  logic step_f;
  logic dir_f;

  glitch_filter #(.STABLE_CYCLES(`GLITCH_CYCLES)) step_filter (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .raw_in   (step_pin_in),
    .level_out(step_f)
  );

  glitch_filter #(.STABLE_CYCLES(`GLITCH_CYCLES)) dir_filter (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .raw_in   (dir_pin_in),
    .level_out(dir_f)
  );

  //////////////////////////////////////////////////////////////////////////
  // Control registers and APB decode.
  logic [31:0] ctrl;
  logic [8:0]  coil_a_serial;
  logic [8:0]  coil_b_serial;
  mstep_t      mstep;
  logic        step_prev;

  wire        step_enable = ctrl[`CTRL_STEP_EN_BIT];
  wire        dual_edge_step_select = ctrl[`CTRL_DUAL_EDGE_BIT];
  wire [3:0]  resolution = ctrl[`CTRL_RES_MSB:`CTRL_RES_LSB];
  wire [4:0]  current_scale = ctrl[`CTRL_SCALE_MSB:`CTRL_SCALE_LSB];

  wire        apb_access = psel_in && penable_in && !pready_out;
  wire        hit_ctrl = (paddr_in == `CTRL_OFFSET);
  wire        hit_coil_a = (paddr_in == `COIL_A_OFFSET);
  wire        hit_coil_b = (paddr_in == `COIL_B_OFFSET);
  wire        hit_status = (paddr_in == `STATUS_OFFSET);
  wire        hit_any = hit_ctrl || hit_coil_a || hit_coil_b || hit_status;
  // Writes land on the edge at which the master sees pready.
  wire        apb_done = psel_in && penable_in && pready_out;
  wire        apb_write = apb_done && pwrite_in && hit_any;
  wire [31:0] status_word = {19'h00000, ext_clock_select_out,
                             stall_flag_out, test_mode_out, mstep};
  wire [31:0] read_value =
    hit_ctrl   ? (ctrl & 32'h00001F3F) :
    hit_coil_a ? {23'h000000, coil_a_serial} :
    hit_coil_b ? {23'h000000, coil_b_serial} :
    hit_status ? status_word : 32'h00000000;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end
    else
    begin
      pready_out  <= apb_access;
      pslverr_out <= apb_access && !hit_any;
      prdata_out  <= (apb_access && !pwrite_in) ? read_value : 32'h00000000;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      ctrl <= `CTRL_RESET;
    else if (apb_write && hit_ctrl)
      ctrl <= pwdata_in & 32'h00001F3F;
  end

  //////////////////////////////////////////////////////////////////////////
  // Serial command port; in test mode it becomes a scan chain.
  logic [19:0] shift_reg;
  logic [4:0]  bit_count;
  logic        sck_prev;
  logic        select_prev;

  wire sck_rise = sck_s && !sck_prev;
  wire sck_fall = !sck_s && sck_prev;
  wire frame_start = !select_n_s && select_prev;
  wire frame_end = select_n_s && !select_prev;
  wire frame_full = (bit_count == 5'(`SPI_CMD_BITS));
  wire command_done = frame_end && frame_full && !test_mode_out;
  wire direct_cmd = (shift_reg[19:18] == `SPI_DIRECT_TAG);
  wire [19:0] status_frame = {stall_flag_out, mstep, 9'h000};

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sck_prev    <= 1'b0;
      select_prev <= 1'b1;
    end
    else
    begin
      sck_prev    <= sck_s;
      select_prev <= select_n_s;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      shift_reg <= 20'h00000;
      bit_count <= 5'h00;
    end
    else if (test_mode_out)
    begin
      if (sck_s)
        shift_reg <= {shift_reg[18:0], sdi_s};
    end
    else if (frame_start)
    begin
      shift_reg <= status_frame;
      bit_count <= 5'h00;
    end
    else if (!select_n_s && sck_rise && !frame_full)
    begin
      shift_reg <= {shift_reg[18:0], sdi_s};
      bit_count <= bit_count + 5'h01;
    end
  end

  // The outgoing bit is taken from the top of the register before shifting.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      serial_data_out          <= 1'b0;
      serial_data_enable_n_out <= 1'b1;
    end
    else
    begin
      serial_data_enable_n_out <= select_n_s && !test_mode_out;
      if (test_mode_out || frame_start || sck_fall)
        serial_data_out <= test_mode_out ? shift_reg[19] :
                           frame_start ? status_frame[19] : shift_reg[19];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      coil_a_serial <= `COIL_RESET;
      coil_b_serial <= `COIL_RESET;
    end
    else if (command_done && direct_cmd)
    begin
      coil_a_serial <= shift_reg[17:9];
      coil_b_serial <= shift_reg[8:0];
    end
    else if (apb_write && hit_coil_a)
      coil_a_serial <= pwdata_in[8:0];
    else if (apb_write && hit_coil_b)
      coil_b_serial <= pwdata_in[8:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // Microstep counter.
  wire [3:0] step_shift = (resolution > `RES_FULL_STEP) ?
                          `RES_FULL_STEP : resolution;
  wire [9:0] step_size = 10'h001 << step_shift;
  wire step_rise = step_f && !step_prev;
  wire step_fall = !step_f && step_prev;
  wire active_edge = step_rise || (dual_edge_step_select && step_fall);

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      step_prev <= 1'b0;
      mstep     <= `MSTEP_RESET;
    end
    else
    begin
      step_prev <= step_f;
      if (active_edge && step_enable)
        mstep <= dir_f ? (mstep - step_size) : (mstep + step_size);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sine lookup, source selection and scaling.
  // Quarter wave sampled mid-interval, so no entry is exactly zero.
  localparam magnitude_t QUARTER_SINE [16] = '{
    8'h0C, 8'h24, 8'h3C, 8'h54, 8'h6B, 8'h80, 8'h94, 8'hA7,
    8'hB8, 8'hC7, 8'hD5, 8'hE0, 8'hEA, 8'hF1, 8'hF6, 8'hF8};

  wire mstep_t     cos_pos = mstep + 10'h100;
  wire [3:0]       idx_a = mstep[8] ? ~mstep[7:4] : mstep[7:4];
  wire [3:0]       idx_b = cos_pos[8] ? ~cos_pos[7:4] : cos_pos[7:4];
  wire [8:0]       sine_a = {mstep[9], QUARTER_SINE[idx_a]};
  wire [8:0]       sine_b = {cos_pos[9], QUARTER_SINE[idx_b]};
  wire [8:0]       chosen_a = step_enable ? sine_a : coil_a_serial;
  wire [8:0]       chosen_b = step_enable ? sine_b : coil_b_serial;
  wire [4:0]       scale_eff = (load_limit_in < current_scale) ?
                               load_limit_in : current_scale;
  wire [5:0]       factor = {1'b0, scale_eff} + 6'h01;
  wire [13:0]      product_a = chosen_a[7:0] * factor;
  wire [13:0]      product_b = chosen_b[7:0] * factor;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      coil_a_target_out   <= 8'h00;
      coil_a_negative_out <= 1'b0;
      coil_b_target_out   <= 8'h00;
      coil_b_negative_out <= 1'b0;
    end
    else
    begin
      coil_a_target_out   <= product_a[12:5];
      coil_a_negative_out <= chosen_a[8];
      coil_b_target_out   <= product_b[12:5];
      coil_b_negative_out <= chosen_b[8];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock source, stall flag and test mode.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      oscillator_enable_out <= 1'b1;
      ext_clock_select_out  <= 1'b0;
      stall_flag_out        <= 1'b0;
      test_mode_out         <= 1'b0;
    end
    else
    begin
      oscillator_enable_out <= !(ext_clock_select_out || extclk_s);
      ext_clock_select_out  <= ext_clock_select_out || extclk_s;
      stall_flag_out        <= stall_detect_in;
      test_mode_out         <= test_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Chopper bridges.
  wire bridge_enable = !enable_n_s && !test_mode_out;

  bridge_phase #(.DEAD_CYCLES(`DEAD_CYCLES), .OFF_CYCLES(`OFF_CYCLES))
  bridge_a (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .enable_in  (bridge_enable),
    .negative_in(coil_a_negative_out),
    .reached_in (reached_a),
    .high1_out  (gate_a_high1_out),
    .low1_out   (gate_a_low1_out),
    .high2_out  (gate_a_high2_out),
    .low2_out   (gate_a_low2_out)
  );

  bridge_phase #(.DEAD_CYCLES(`DEAD_CYCLES), .OFF_CYCLES(`OFF_CYCLES))
  bridge_b (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .enable_in  (bridge_enable),
    .negative_in(coil_b_negative_out),
    .reached_in (reached_b),
    .high1_out  (gate_b_high1_out),
    .low1_out   (gate_b_low1_out),
    .high2_out  (gate_b_high2_out),
    .low2_out   (gate_b_low2_out)
  );
endmodule // step_dir_microstep_frontend

/* step_map.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef STEP_MAP_SVH
`define STEP_MAP_SVH

`define CTRL_OFFSET        8'h00
`define COIL_A_OFFSET      8'h04
`define COIL_B_OFFSET      8'h08
`define STATUS_OFFSET      8'h0C

`define CTRL_STEP_EN_BIT   0
`define CTRL_DUAL_EDGE_BIT 1
`define CTRL_RES_LSB       2
`define CTRL_RES_MSB       5
`define CTRL_SCALE_LSB     8
`define CTRL_SCALE_MSB     12
`define CTRL_RESET         32'h00001F01
`define COIL_RESET         9'h000
`define MSTEP_RESET        10'h000
`define RES_FULL_STEP      4'h8

`define SPI_CMD_BITS       20
`define SPI_DIRECT_TAG     2'h0

`define CLK_PERIOD_NS      100
`define GLITCH_NS          60
`define GLITCH_CYCLES      ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEAD_NS            100
`define DEAD_CYCLES        ((`DEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OFF_NS             2400
`define OFF_CYCLES         ((`OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* step_pkg.sv */
// Types shared by the step/direction front end.
package step_pkg;
  typedef logic [7:0] magnitude_t;
  typedef logic [9:0] mstep_t;
  typedef enum logic [1:0] {BRIDGE_IDLE, BRIDGE_DEAD, BRIDGE_DRIVE,
                            BRIDGE_DECAY} bridge_state_t;
endpackage

/* glitch_filter.sv */
// Two-stage synchroniser followed by a minimum-width glitch filter.
module glitch_filter #(
  parameter int STABLE_CYCLES = 1
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic raw_in,
  output logic      level_out
);
  logic       sync1;
  logic       sync2;
  logic [3:0] stable_count;
  wire        differs = (sync2 != level_out);
  wire        long_enough = (stable_count >= 4'(STABLE_CYCLES - 1));

  always_ff @(posedge clk_in)
  begin
    sync1 <= raw_in;
    sync2 <= sync1;
  end

  // A new level is taken only after it has stood for the filter time.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      level_out    <= 1'b0;
      stable_count <= 4'h0;
    end
    else if (!differs)
      stable_count <= 4'h0;
    else if (long_enough)
    begin
      level_out    <= sync2;
      stable_count <= 4'h0;
    end
    else
      stable_count <= stable_count + 4'h1;
  end
endmodule // glitch_filter

/* bridge_phase.sv */
// One H-bridge chopper sequencer with break-before-make dead time.
module bridge_phase #(
  parameter int DEAD_CYCLES = 1,
  parameter int OFF_CYCLES  = 24,
  parameter int TIMER_W     = 8
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic enable_in,
  input  wire logic negative_in,
  input  wire logic reached_in,
  output logic      high1_out,
  output logic      low1_out,
  output logic      high2_out,
  output logic      low2_out
);
  import step_pkg::*;

  localparam logic [TIMER_W-1:0] DEAD_LOAD = TIMER_W'(DEAD_CYCLES - 1);
  localparam logic [TIMER_W-1:0] OFF_LOAD  = TIMER_W'(OFF_CYCLES - 1);

  bridge_state_t      state;
  logic [TIMER_W-1:0] timer;
  logic               to_drive;
  logic               negative;
  wire                expired = (timer == '0);
  wire                driving = (state == BRIDGE_DRIVE);
  wire                decaying = (state == BRIDGE_DECAY);

  always_ff @(posedge clk_in)
  begin
    if (reset_in || !enable_in)
    begin
      state    <= BRIDGE_IDLE;
      timer    <= '0;
      to_drive <= 1'b1;
      negative <= 1'b0;
    end
    else
    begin
      unique case (state)
        BRIDGE_IDLE:
        begin
          state    <= BRIDGE_DEAD;
          timer    <= DEAD_LOAD;
          to_drive <= 1'b1;
        end
        BRIDGE_DEAD:
          if (!expired)
            timer <= timer - 1'b1;
          else if (to_drive)
          begin
            state    <= BRIDGE_DRIVE;
            negative <= negative_in;
          end
          else
          begin
            state <= BRIDGE_DECAY;
            timer <= OFF_LOAD;
          end
        BRIDGE_DRIVE:
          if (reached_in)
          begin
            state    <= BRIDGE_DEAD;
            timer    <= DEAD_LOAD;
            to_drive <= 1'b0;
          end
        BRIDGE_DECAY:
          if (!expired)
            timer <= timer - 1'b1;
          else
          begin
            state    <= BRIDGE_DEAD;
            timer    <= DEAD_LOAD;
            to_drive <= 1'b1;
          end
      endcase
    end
  end

  // Gates follow the state one cycle late; the dead state keeps them apart.
  always_ff @(posedge clk_in)
  begin
    if (reset_in || !enable_in)
    begin
      high1_out <= 1'b0;
      low1_out  <= 1'b0;
      high2_out <= 1'b0;
      low2_out  <= 1'b0;
    end
    else
    begin
      high1_out <= driving && !negative;
      low2_out  <= (driving && !negative) || decaying;
      high2_out <= driving && negative;
      low1_out  <= (driving && negative) || decaying;
    end
  end
endmodule // bridge_phase

/* step_dir_microstep_frontend_chk.sv */
// Pin-level checks for the step/direction front end.
module step_dir_microstep_frontend_chk (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic stall_detect_in,
  input wire logic stall_flag_out,
  input wire logic power_stage_enable_n_in,
  input wire logic ext_clock_pin_in,
  input wire logic ext_clock_select_out,
  input wire logic oscillator_enable_out,
  input wire logic factory_test_select_in,
  input wire logic test_mode_out,
  input wire logic serial_select_n_in,
  input wire logic serial_data_enable_n_out,
  input wire logic gate_a_high1_out,
  input wire logic gate_a_low1_out,
  input wire logic gate_a_high2_out,
  input wire logic gate_a_low2_out,
  input wire logic gate_b_high1_out,
  input wire logic gate_b_low1_out,
  input wire logic gate_b_high2_out,
  input wire logic gate_b_low2_out
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic gates_on = gate_a_high1_out | gate_a_low1_out |
    gate_a_high2_out | gate_a_low2_out | gate_b_high1_out |
    gate_b_low1_out | gate_b_high2_out | gate_b_low2_out;
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////
  AST_STALL_ECHO: assert property (
    !$past(reset_in) |-> stall_flag_out == $past(stall_detect_in))
    else $error("stall flag does not follow stall detect");
  AST_POWER_OFF: assert property (
    power_stage_enable_n_in [*4] |=> !gates_on)
    else $error("gate on while power stage disabled");
  AST_LEG_APART: assert property (
    !(gate_a_high1_out && gate_a_low1_out) &&
    !(gate_a_high2_out && gate_a_low2_out) &&
    !(gate_b_high1_out && gate_b_low1_out) &&
    !(gate_b_high2_out && gate_b_low2_out))
    else $error("high and low gate of one leg on together");
  AST_DEAD_TIME: assert property (
    $rose(gate_a_high1_out) |-> !$past(gate_a_low1_out))
    else $error("no dead cycle before high side turns on");
  AST_ONE_SOURCE: assert property (
    oscillator_enable_out != ext_clock_select_out)
    else $error("oscillator and external clock both or neither");
  AST_EXT_STICKY: assert property (
    ext_clock_select_out |=> ext_clock_select_out)
    else $error("external clock selection dropped");
  AST_EXT_LATCH: assert property (
    ext_clock_pin_in [*3] |-> ##[1:4] ext_clock_select_out)
    else $error("external clock high not latched");
  AST_TEST_ENTRY: assert property (
    factory_test_select_in [*3] |-> ##[1:4] test_mode_out)
    else $error("test input did not enter test mode");
  AST_SDO_DRIVEN: assert property (
    (!serial_select_n_in) [*3] |-> ##[1:4] !serial_data_enable_n_out)
    else $error("serial output not driven while selected");
endmodule // step_dir_microstep_frontend_chk

/* motion_ctrl_model.sv */
// Motion controller model: step/direction pulses and serial frames.
module motion_ctrl_model (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  output logic      step_out,
  output logic      dir_out,
  output logic      select_n_out,
  output logic      sck_out,
  output logic      sdi_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    step_out = 1'b0;
    dir_out = 1'b0;
    select_n_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Levels are held 6 cycles, well past the input filter.
  task automatic step(input logic d, input logic both);
    dir_out <= d;
    cyc(6);
    step_out <= ~step_out;
    cyc(6);
    if (!both)
    begin
      step_out <= ~step_out;
      cyc(6);
    end
  endtask
  task automatic frame(input logic [19:0] cmd, output logic [19:0] st);
    select_n_out <= 1'b0;
    for (int i = 19; i >= 0; i--)
    begin
      sdi_out <= cmd[i];
      cyc(4);
      st[i] = sdo_in;
      sck_out <= 1'b1;
      cyc(4);
      sck_out <= 1'b0;
    end
    cyc(4);
    select_n_out <= 1'b1;
    sdi_out <= ~cmd[0];
    cyc(6);
  endtask
endmodule // motion_ctrl_model

/* test_step_dir_microstep_frontend.sv */
// Self-checking bench for the step/direction front end.
module test_step_dir_microstep_frontend;
  timeunit 1ns;
  timeprecision 1ns;
  import step_pkg::*;
  logic clk_in = 1'b0, reset_in = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ftest = 1'b0, ext_pin = 1'b0, power_stage_enable_n = 1'b1;
  logic comp_a = 1'b0, comp_b = 1'b0, stall_det = 1'b0, e;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [4:0]  load = 5'h1F;
  logic [19:0] st;
  logic pready, pslverr, sdo, sdo_en_n, osc_en, ext_sel, stall_flag;
  logic test_mode, step, dir, sel_n, sck, sdi, neg_a, neg_b;
  logic ga_h1, ga_h2, gb_h1, gb_h2;
  magnitude_t tgt_a, tgt_b;
  int error_cnt = 0, comparisons = 0;
  initial
  begin
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    comp_a <= ga_h1 | ga_h2;
    comp_b <= gb_h1 | gb_h2;
  end
  motion_ctrl_model i_ctrl (.clk_in(clk_in), .sdo_in(sdo),
    .step_out(step), .dir_out(dir), .select_n_out(sel_n),
    .sck_out(sck), .sdi_out(sdi));
  step_dir_microstep_frontend i_dut (.clk_in(clk_in),
    .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .step_pin_in(step), .dir_pin_in(dir), .serial_select_n_in(sel_n),
    .serial_clock_in(sck), .serial_data_in(sdi),
    .serial_data_out(sdo), .serial_data_enable_n_out(sdo_en_n),
    .factory_test_select_in(ftest), .ext_clock_pin_in(ext_pin),
    .oscillator_enable_out(osc_en), .ext_clock_select_out(ext_sel),
    .power_stage_enable_n_in(power_stage_enable_n), .comparator_a_in(comp_a),
    .comparator_b_in(comp_b), .load_limit_in(load),
    .stall_detect_in(stall_det), .coil_a_target_out(tgt_a),
    .coil_a_negative_out(neg_a), .coil_b_target_out(tgt_b),
    .coil_b_negative_out(neg_b), .gate_a_high1_out(ga_h1),
    .gate_a_low1_out(), .gate_a_high2_out(ga_h2), .gate_a_low2_out(),
    .gate_b_high1_out(gb_h1), .gate_b_low1_out(),
    .gate_b_high2_out(gb_h2), .gate_b_low2_out(),
    .stall_flag_out(stall_flag), .test_mode_out(test_mode));
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, y);
    comparisons++;
    if (y !== x)
    begin
      $display("unexpected %s: expected %h, seen %h", nm, x, y);
      error_cnt++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // One APB transfer; waits for pready under a bound.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      error_cnt++;
      tally_and_finish();
    end
    @(posedge clk_in);
  endtask
  task automatic move(input logic d, input logic both);
    i_ctrl.step(d, both);
    apb(1'b0, 8'h0C, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    power_stage_enable_n <= 1'b0;
    @(posedge clk_in);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h00001F01, q);
    chk("osc reset", 32'h1, osc_en);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped data", 32'h0, q);
    chk("unmapped error", 32'h1, e);
    apb(1'b1, 8'h0C, 32'h00000FFF);
    apb(1'b0, 8'h0C, 32'h0);
    chk("status readonly", 32'h0, q);
    for (int r = 0; r < 9; r++)
    begin
      apb(1'b1, 8'h00, 32'h00001F01 | (r << 2));
      move(1'b0, 1'b0);
      chk("mstep up", (10'h002 << r) - 10'h001, q[9:0]);
    end
    apb(1'b1, 8'h00, 32'h00001F21);
    move(1'b1, 1'b0);
    chk("mstep down", 10'h0FF, q[9:0]);
    move(1'b1, 1'b0);
    chk("wrap down", 10'h3FF, q[9:0]);
    apb(1'b1, 8'h00, 32'h00001F01);
    move(1'b0, 1'b0);
    chk("wrap up", 10'h000, q[9:0]);
    cyc(2);
    chk("sine zero", 8'h0C, tgt_a);
    apb(1'b1, 8'h00, 32'h00001F21);
    move(1'b0, 1'b0);
    cyc(2);
    chk("cosine zero", 8'h0C, tgt_b);
    chk("sine peak", 32'h1, tgt_a > 8'h00);
    apb(1'b1, 8'h00, 32'h00001F23);
    move(1'b0, 1'b1);
    move(1'b0, 1'b1);
    chk("dual edge", 10'h300, q[9:0]);
    apb(1'b1, 8'h00, 32'h00001F20);
    move(1'b0, 1'b0);
    chk("step disabled", 10'h300, q[9:0]);
    stall_det <= 1'b1;
    cyc(2);
    i_ctrl.frame({2'h0, 9'h040, 9'h120}, st);
    chk("status word", {1'b1, 10'h300, 9'h000}, st);
    chk("stall flag", 32'h1, stall_flag);
    chk("coil a", 9'h040, {neg_a, tgt_a});
    chk("coil b", 9'h120, {neg_b, tgt_b});
    i_ctrl.frame({2'h1, 9'h0FF, 9'h0FF}, st);
    chk("other tag", 9'h040, {neg_a, tgt_a});
    apb(1'b1, 8'h00, 32'h00000F20);
    cyc(3);
    chk("scaled", 8'h20, tgt_a);
    apb(1'b1, 8'h00, 32'h00001F20);
    load <= 5'h07;
    cyc(3);
    chk("load scaled", 8'h10, tgt_a);
    apb(1'b0, 8'h04, 32'h0);
    chk("coil reg", 32'h00000040, q);
    ftest <= 1'b1;
    cyc(6);
    chk("test mode", 32'h1, test_mode);
    chk("test sdo", 32'h0, sdo_en_n);
    i_ctrl.frame(20'hFFFFF, st);
    chk("scan out", 32'h1, sdo);
    ftest <= 1'b0;
    ext_pin <= 1'b1;
    cyc(6);
    ext_pin <= 1'b0;
    cyc(6);
    chk("ext select", 32'h1, ext_sel);
    chk("osc off", 32'h0, osc_en);
    power_stage_enable_n <= 1'b1;
    cyc(6);
    tally_and_finish();
  end
  initial
  begin
    repeat (100000) @(posedge clk_in);
    error_cnt++;
    tally_and_finish();
  end
endmodule // test_step_dir_microstep_frontend

bind step_dir_microstep_frontend step_dir_microstep_frontend_chk i_chk (
  .clk_in, .reset_in, .stall_detect_in, .stall_flag_out,
  .power_stage_enable_n_in, .ext_clock_pin_in, .ext_clock_select_out,
  .oscillator_enable_out, .factory_test_select_in, .test_mode_out,
  .serial_select_n_in, .serial_data_enable_n_out, .gate_a_high1_out,
  .gate_a_low1_out, .gate_a_high2_out, .gate_a_low2_out,
  .gate_b_high1_out, .gate_b_low1_out, .gate_b_high2_out,
  .gate_b_low2_out);
